// ===== common/sync_ref_pkg.sv
package sync_ref_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W             = 16;
  localparam int          DATA_W             = 8;
  localparam logic [15:0] ADDR_SAMPLING_PATH = 16'h019e;
  localparam logic [15:0] ADDR_CAPTURE_EN    = 16'h0fb0;
  localparam logic [15:0] ADDR_DELAY_EN      = 16'h0fb1;
  localparam logic [15:0] ADDR_FINE_DELAY    = 16'h0fb2;
  localparam logic [15:0] ADDR_SUPERFINE     = 16'h0fb3;
  localparam logic [15:0] ADDR_EDGE_POLARITY = 16'h0fb6;
  localparam logic [15:0] ADDR_SETUP_MARGIN  = 16'h0fb7;
  localparam logic [15:0] ADDR_HOLD_MARGIN   = 16'h0fb8;
  localparam logic [15:0] ADDR_INPUT_MODE    = 16'h0fb9;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int       BIT_SAMPLING_PATH = 0;
  localparam int       BIT_CAPTURE_EN    = 3;
  localparam int       BIT_FINE_EN       = 0;
  localparam int       BIT_SUPERFINE_EN  = 1;
  localparam int       BIT_EDGE_FALL     = 0;
  localparam int       BIT_TRANS_FALL    = 1;
  localparam int       BIT_SINGLE_ENDED  = 4;
  localparam logic     RST_BIT           = 1'b0;
  localparam logic [7:0] RST_CODE        = 8'h00;
  localparam logic [7:0] READ_ZERO       = 8'h00;

  // ---------------------------------------------------------------
  // Delay line, margin counter and reference divider figures
  // ---------------------------------------------------------------
  localparam logic [7:0] FINE_MAX_CODE     = 8'h2f;
  localparam int         FINE_STEP_FS      = 1100;
  localparam int         FINE_RANGE_FS     = 56000;
  localparam int         SUPERFINE_STEP_FS = 16;
  localparam logic [7:0] MARGIN_MAX        = 8'hff;
  localparam int         REF_DIV_DEFAULT   = 4;

  typedef struct packed {
    logic       path_direct;
    logic       capture_en;
    logic       fine_en;
    logic       superfine_en;
    logic       trans_fall;
    logic       edge_fall;
    logic       single_ended;
    logic [7:0] fine_code;
    logic [7:0] superfine_code;
  } cfg_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] hold;
  } margin_t;

  typedef enum logic [1:0] {
    MON_OFF   = 2'b00,
    MON_ARMED = 2'b01,
    MON_HOLD  = 2'b11
  } mon_state_t;

endpackage

// ===== core/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] d_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_next;

  // A bit moves only once the last two stages agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : d_out[i];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      d_out  <= '0;
    end
    else
    begin
      s1_reg <= d_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      d_out  <= out_next;
    end
  end

endmodule

// ===== core/margin_monitor.sv
`timescale 1ns/1ps
module margin_monitor (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 enable,
  input  wire logic                 sample,
  input  wire logic                 valid_capture,
  output sync_ref_pkg::margin_t     margin
);

  sync_ref_pkg::mon_state_t state_reg;
  sync_ref_pkg::mon_state_t state_next;
  logic [7:0]               since_reg;
  logic                     prev_reg;
  wire                      changed = sample != prev_reg;
  wire                      sat     = since_reg == sync_ref_pkg::MARGIN_MAX;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      sync_ref_pkg::MON_OFF:   state_next = sync_ref_pkg::MON_ARMED;
      sync_ref_pkg::MON_ARMED: if (valid_capture) state_next = sync_ref_pkg::MON_HOLD;
      sync_ref_pkg::MON_HOLD:  if (changed) state_next = sync_ref_pkg::MON_ARMED;
      default:                 state_next = sync_ref_pkg::MON_OFF;
    endcase
    if (!enable)
      state_next = sync_ref_pkg::MON_OFF;
  end

  // Counter saturates so a slow reference never wraps into a false margin
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= sync_ref_pkg::MON_OFF;
      since_reg <= sync_ref_pkg::RST_CODE;
      prev_reg  <= sync_ref_pkg::RST_BIT;
      margin    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      prev_reg  <= sample;
      since_reg <= changed ? sync_ref_pkg::RST_CODE : (sat ? since_reg : since_reg + 8'h01);
      if (enable && state_reg == sync_ref_pkg::MON_ARMED && valid_capture)
        margin.setup <= since_reg;
      if (enable && state_reg == sync_ref_pkg::MON_HOLD && changed)
        margin.hold <= since_reg;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_margin_frozen_off: assert property (!enable |=> $stable(margin))
    else $error("margin changed while capture disabled");
  a_setup_from_count: assert property (
    enable && state_reg == sync_ref_pkg::MON_ARMED && valid_capture
    |=> margin.setup == $past(since_reg))
    else $error("setup margin not taken from counter");
  c_hold_measured: cover property (state_reg == sync_ref_pkg::MON_HOLD ##1
                                   state_reg == sync_ref_pkg::MON_ARMED);

endmodule

// ===== core/sync_ref_capture_config.sv
`timescale 1ns/1ps
module sync_ref_capture_config #(
  parameter int REF_DIV = sync_ref_pkg::REF_DIV_DEFAULT
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [7:0]  reg_wr_data,
  output logic      [7:0]  reg_rd_data,
  output logic             reg_rd_valid,
  input  wire logic        sync_ref_in,
  input  wire logic        dev_clk_in,
  output logic             sync_ref_event,
  output logic             sync_ref_level,
  output logic      [7:0]  fine_delay_code_out,
  output logic      [7:0]  superfine_delay_code_out,
  output logic             single_ended_select_out
);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  sync_ref_pkg::cfg_t    cfg_reg;
  sync_ref_pkg::cfg_t    cfg_next;
  sync_ref_pkg::margin_t margin;

  function automatic logic [7:0] bit_at(input logic v, input int pos);
    logic [7:0] r;
    r      = sync_ref_pkg::READ_ZERO;
    r[pos] = v;
    return r;
  endfunction

  function automatic logic [7:0] fine_eff(input logic en, input logic [7:0] code);
    logic [7:0] r;
    r = sync_ref_pkg::RST_CODE;
    if (en)
      r = (code > sync_ref_pkg::FINE_MAX_CODE) ? sync_ref_pkg::FINE_MAX_CODE : code;
    return r;
  endfunction

  wire wr_path    = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_SAMPLING_PATH;
  wire wr_cap_en  = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_CAPTURE_EN;
  wire wr_dly_en  = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_DELAY_EN;
  wire wr_fine    = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_FINE_DELAY;
  wire wr_sfine   = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_SUPERFINE;
  wire wr_edge    = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_EDGE_POLARITY;
  wire wr_mode    = reg_wr_en && reg_addr == sync_ref_pkg::ADDR_INPUT_MODE;

  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_path)
      cfg_next.path_direct = reg_wr_data[sync_ref_pkg::BIT_SAMPLING_PATH];
    if (wr_cap_en)
      cfg_next.capture_en = reg_wr_data[sync_ref_pkg::BIT_CAPTURE_EN];
    if (wr_dly_en)
    begin
      cfg_next.fine_en      = reg_wr_data[sync_ref_pkg::BIT_FINE_EN];
      cfg_next.superfine_en = reg_wr_data[sync_ref_pkg::BIT_SUPERFINE_EN];
    end
    if (wr_fine)
      cfg_next.fine_code = reg_wr_data;
    if (wr_sfine)
      cfg_next.superfine_code = reg_wr_data;
    if (wr_edge)
    begin
      cfg_next.trans_fall = reg_wr_data[sync_ref_pkg::BIT_TRANS_FALL];
      cfg_next.edge_fall  = reg_wr_data[sync_ref_pkg::BIT_EDGE_FALL];
    end
    if (wr_mode)
      cfg_next.single_ended = reg_wr_data[sync_ref_pkg::BIT_SINGLE_ENDED];
  end

  // ---------------------------------------------------------------
  // Read decode
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb
  begin
    case (reg_addr)
      sync_ref_pkg::ADDR_SAMPLING_PATH:
        rd_mux = bit_at(cfg_reg.path_direct, sync_ref_pkg::BIT_SAMPLING_PATH);
      sync_ref_pkg::ADDR_CAPTURE_EN:
        rd_mux = bit_at(cfg_reg.capture_en, sync_ref_pkg::BIT_CAPTURE_EN);
      sync_ref_pkg::ADDR_DELAY_EN:
        rd_mux = bit_at(cfg_reg.fine_en, sync_ref_pkg::BIT_FINE_EN)
               | bit_at(cfg_reg.superfine_en, sync_ref_pkg::BIT_SUPERFINE_EN);
      sync_ref_pkg::ADDR_FINE_DELAY:
        rd_mux = cfg_reg.fine_code;
      sync_ref_pkg::ADDR_SUPERFINE:
        rd_mux = cfg_reg.superfine_code;
      sync_ref_pkg::ADDR_EDGE_POLARITY:
        rd_mux = bit_at(cfg_reg.trans_fall, sync_ref_pkg::BIT_TRANS_FALL)
               | bit_at(cfg_reg.edge_fall, sync_ref_pkg::BIT_EDGE_FALL);
      sync_ref_pkg::ADDR_SETUP_MARGIN:
        rd_mux = margin.setup;
      sync_ref_pkg::ADDR_HOLD_MARGIN:
        rd_mux = margin.hold;
      sync_ref_pkg::ADDR_INPUT_MODE:
        rd_mux = bit_at(cfg_reg.single_ended, sync_ref_pkg::BIT_SINGLE_ENDED);
      default:
        rd_mux = sync_ref_pkg::READ_ZERO;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg_reg      <= '0;
      reg_rd_data  <= sync_ref_pkg::READ_ZERO;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      cfg_reg      <= cfg_next;
      reg_rd_valid <= reg_rd_en;
      reg_rd_data  <= reg_rd_en ? rd_mux : sync_ref_pkg::READ_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // Delay stage controls
  // ---------------------------------------------------------------
  // Fine codes above the top step add nothing, so they are clipped here; super-fine codes pass unclipped
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      fine_delay_code_out      <= sync_ref_pkg::RST_CODE;
      superfine_delay_code_out <= sync_ref_pkg::RST_CODE;
      single_ended_select_out  <= sync_ref_pkg::RST_BIT;
    end
    else
    begin
      fine_delay_code_out      <= fine_eff(cfg_reg.fine_en, cfg_reg.fine_code);
      superfine_delay_code_out <= cfg_reg.superfine_en ?
                                  cfg_reg.superfine_code : sync_ref_pkg::RST_CODE;
      single_ended_select_out  <= cfg_reg.single_ended;
    end
  end

  // ---------------------------------------------------------------
  // Sampling path
  // ---------------------------------------------------------------
  logic [1:0] pins_sync;
  logic [7:0] ref_cnt_reg;
  logic       ref_q_reg;
  logic       hs_q_reg;
  logic       clk_prev_reg;
  wire        ref_en  = ref_cnt_reg == 8'(REF_DIV - 1);
  wire        s_sync  = pins_sync[0];
  wire        clk_now = pins_sync[1];
  wire        rise    = clk_now && !clk_prev_reg;
  wire        fall    = !clk_now && clk_prev_reg;
  wire        strobe  = cfg_reg.edge_fall ? fall : rise;
  wire        differs = hs_q_reg != sync_ref_level;
  wire        dir_ok  = hs_q_reg == !cfg_reg.trans_fall;
  wire        valid_w = cfg_reg.capture_en && strobe && differs && dir_ok;

  pin_sync #(
    .W (2)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .d_in    ({dev_clk_in, sync_ref_in}),
    .d_out   (pins_sync)
  );

  // Reference path costs latency but tolerates a late input
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ref_cnt_reg    <= sync_ref_pkg::RST_CODE;
      ref_q_reg      <= sync_ref_pkg::RST_BIT;
      hs_q_reg       <= sync_ref_pkg::RST_BIT;
      clk_prev_reg   <= sync_ref_pkg::RST_BIT;
      sync_ref_level <= sync_ref_pkg::RST_BIT;
      sync_ref_event <= 1'b0;
    end
    else
    begin
      ref_cnt_reg  <= ref_en ? sync_ref_pkg::RST_CODE : ref_cnt_reg + 8'h01;
      if (ref_en)
        ref_q_reg <= s_sync;
      hs_q_reg     <= cfg_reg.path_direct ? s_sync : ref_q_reg;
      clk_prev_reg <= clk_now;
      // Any enabled strobe moves the level, so a wrong transition rearms
      if (strobe && cfg_reg.capture_en)
        sync_ref_level <= hs_q_reg;
      sync_ref_event <= valid_w;
    end
  end

  margin_monitor u_margin_monitor (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .enable        (cfg_reg.capture_en),
    .sample        (hs_q_reg),
    .valid_capture (valid_w),
    .margin        (margin)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_direct_path_sel: assert property (cfg_reg.path_direct |=> hs_q_reg == $past(s_sync))
    else $error("direct path did not follow input");
  a_ref_path_sel: assert property (!cfg_reg.path_direct |=> hs_q_reg == $past(ref_q_reg))
    else $error("reference path did not follow reference stage");
  a_ref_stage_load: assert property (
    ref_en |=> ref_q_reg == $past(s_sync))
    else $error("reference stage missed its sample");
  a_ref_stage_hold: assert property (
    !ref_en |=> $stable(ref_q_reg))
    else $error("reference stage moved between samples");
  a_path_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_SAMPLING_PATH
    |=> reg_rd_valid && reg_rd_data == {7'h00, $past(cfg_reg.path_direct)})
    else $error("sampling path readback wrong");
  a_fine_off_zero: assert property (!cfg_reg.fine_en |=> fine_delay_code_out == 8'h00)
    else $error("fine delay active while disabled");
  a_superfine_off_zero: assert property (
    !cfg_reg.superfine_en |=> superfine_delay_code_out == sync_ref_pkg::RST_CODE)
    else $error("super-fine delay active while disabled");
  a_delay_en_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_DELAY_EN |=> reg_rd_data
    == {6'h00, $past(cfg_reg.superfine_en), $past(cfg_reg.fine_en)})
    else $error("delay enables readback wrong");
  a_fine_clip_max: assert property (
    cfg_reg.fine_en && cfg_reg.fine_code > sync_ref_pkg::FINE_MAX_CODE
    |=> fine_delay_code_out == sync_ref_pkg::FINE_MAX_CODE)
    else $error("fine delay not clipped");
  a_fine_pass_code: assert property (
    cfg_reg.fine_en && cfg_reg.fine_code <= sync_ref_pkg::FINE_MAX_CODE
    |=> fine_delay_code_out == $past(cfg_reg.fine_code))
    else $error("fine delay code not passed");
  a_superfine_pass: assert property (
    cfg_reg.superfine_en
    |=> superfine_delay_code_out == $past(cfg_reg.superfine_code))
    else $error("super-fine code not passed");
  a_event_polarity: assert property (
    sync_ref_event
    |-> sync_ref_level == !$past(cfg_reg.trans_fall) && $changed(sync_ref_level))
    else $error("event on wrong transition");
  a_edge_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_EDGE_POLARITY |=> reg_rd_data
    == {6'h00, $past(cfg_reg.trans_fall), $past(cfg_reg.edge_fall)})
    else $error("edge and transition readback wrong");
  a_edge_select: assert property (
    sync_ref_event |-> ($past(cfg_reg.edge_fall) ? $past(fall) : $past(rise)))
    else $error("capture on wrong clock edge");
  a_setup_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_SETUP_MARGIN
    |=> reg_rd_valid && reg_rd_data == $past(margin.setup))
    else $error("setup margin readback wrong");
  a_hold_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_HOLD_MARGIN
    |=> reg_rd_valid && reg_rd_data == $past(margin.hold))
    else $error("hold margin readback wrong");
  a_rd_idle_zero: assert property (
    !reg_rd_en |=> !reg_rd_valid && reg_rd_data == sync_ref_pkg::READ_ZERO)
    else $error("read data shown without a read");
  a_mode_output: assert property (
    wr_mode ##1 1'b1 |=> single_ended_select_out
    == $past(reg_wr_data[sync_ref_pkg::BIT_SINGLE_ENDED], 2))
    else $error("single-ended select not applied");
  a_mode_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_INPUT_MODE
    |=> reg_rd_data == {3'h0, $past(cfg_reg.single_ended), 4'h0})
    else $error("input mode readback wrong");
  a_disabled_quiet: assert property (!cfg_reg.capture_en |=> !sync_ref_event)
    else $error("event while capture disabled");
  a_level_frozen_off: assert property (
    !cfg_reg.capture_en |=> $stable(sync_ref_level))
    else $error("level moved while capture disabled");
  a_capture_readback: assert property (
    reg_rd_en && reg_addr == sync_ref_pkg::ADDR_CAPTURE_EN
    |=> reg_rd_data == {4'h0, $past(cfg_reg.capture_en), 3'h0})
    else $error("capture enable readback wrong");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  c_rise_event: cover property (sync_ref_event && !cfg_reg.trans_fall);
  c_fall_event: cover property (sync_ref_event && cfg_reg.trans_fall && cfg_reg.edge_fall);
  c_direct_event: cover property (sync_ref_event && cfg_reg.path_direct);
  c_ref_event: cover property (sync_ref_event && !cfg_reg.path_direct);

endmodule

// ===== verification/clk_sysref_gen.sv
`timescale 1ns/1ps
module clk_sysref_gen #(
  parameter int HALF = 6
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic sysref_req,
  output logic      dev_clk,
  output logic      sysref
);
  int cnt;

  // ---------------------------------------------------------------
  // Device clock and reference pulse
  // ---------------------------------------------------------------
  // Reference moves mid-phase, so either capture edge sees it settled
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt     <= 0;
      dev_clk <= 1'b0;
      sysref  <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1)
        dev_clk <= ~dev_clk;
      if (cnt == HALF / 2)
        sysref <= sysref_req;
    end
  end
endmodule

// ===== verification/sync_ref_capture_config_tb_top.sv
`timescale 1ns/1ps
module sync_ref_capture_config_tb_top;
  logic        sys_clk;
  logic        rst;
  logic [15:0] reg_addr;
  logic        reg_wr_en;
  logic        reg_rd_en;
  logic [7:0]  reg_wr_data;
  logic [7:0]  reg_rd_data;
  logic        reg_rd_valid;
  logic        sync_ref_in;
  logic        dev_clk_in;
  logic        sync_ref_event;
  logic        sync_ref_level;
  logic [7:0]  fine_out;
  logic [7:0]  sf_out;
  logic        se_out;
  logic        sysref_req;
  int          num_errors;
  int          num_checks;
  int          ev_count = 0;
  int          ev_base;
  int          cyc = 0;
  logic [7:0]  rd;
  logic [7:0]  setup_snap;
  logic [7:0]  hold_snap;
  logic [15:0] wa [9] = '{16'h019e, 16'h0fb0, 16'h0fb1, 16'h0fb2, 16'h0fb3,
                          16'h0fb6, 16'h0fb7, 16'h0fb8, 16'h0fb9};
  logic [7:0]  wd [9] = '{8'hff, 8'hff, 8'hff, 8'ha5, 8'h5a, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0]  we [9] = '{8'h01, 8'h08, 8'h03, 8'ha5, 8'h5a, 8'h03, 8'h00, 8'h00, 8'h10};
  logic [7:0]  fc [4] = '{8'h2e, 8'h2f, 8'h30, 8'hff};
  logic [7:0]  fe [4] = '{8'h2e, 8'h2f, 8'h2f, 8'h2f};

  sync_ref_capture_config dut_u (
    .sys_clk                  (sys_clk),
    .rst                      (rst),
    .reg_addr                 (reg_addr),
    .reg_wr_en                (reg_wr_en),
    .reg_rd_en                (reg_rd_en),
    .reg_wr_data              (reg_wr_data),
    .reg_rd_data              (reg_rd_data),
    .reg_rd_valid             (reg_rd_valid),
    .sync_ref_in              (sync_ref_in),
    .dev_clk_in               (dev_clk_in),
    .sync_ref_event           (sync_ref_event),
    .sync_ref_level           (sync_ref_level),
    .fine_delay_code_out      (fine_out),
    .superfine_delay_code_out (sf_out),
    .single_ended_select_out  (se_out)
  );

  clk_sysref_gen gen_u (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .sysref_req (sysref_req),
    .dev_clk    (dev_clk_in),
    .sysref     (sync_ref_in)
  );

  // ---------------------------------------------------------------
  // Clock, event count, hang guard
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    cyc++;
    if (sync_ref_event === 1'b1)
      ev_count++;
    // Whole run needs about 1530 cycles
    if (cyc == 4000)
    begin
      num_errors++;
      $display("ERROR timeout expected end seen none");
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    check_val("read valid", 8'h01, {7'h0, reg_rd_valid});
    d = reg_rd_data;
  endtask

  task automatic check_reg(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_read(a, d);
    check_val($sformatf("register %h", a), exp, d);
  endtask

  task automatic check_outs(input logic [7:0] f, input logic [7:0] s, input logic e);
    repeat (3) @(posedge sys_clk);
    #1;
    check_val("fine out", f, fine_out);
    check_val("superfine out", s, sf_out);
    check_val("single ended out", {7'h0, e}, {7'h0, se_out});
  endtask

  task automatic sysref_move(input logic v);
    @(posedge sys_clk);
    sysref_req <= v;
    repeat (48) @(posedge sys_clk);
  endtask

  // Input is first set to the valid level, then takes the wrong transition, then the valid one
  task automatic edge_case(input logic path, input logic efall, input logic tfall);
    int b0;
    int b1;
    reg_write(sync_ref_pkg::ADDR_SAMPLING_PATH, {7'h0, path});
    reg_write(sync_ref_pkg::ADDR_EDGE_POLARITY, {6'h0, tfall, efall});
    sysref_move(!tfall);
    b0 = ev_count;
    sysref_move(tfall);
    check_val("wrong transition", 8'h00, 8'(ev_count - b0));
    check_val("wrong level", {7'h0, tfall}, {7'h0, sync_ref_level});
    b1 = ev_count;
    sysref_move(!tfall);
    check_val("valid transition", 8'h01, 8'(ev_count - b1));
    check_val("captured level", {7'h0, !tfall}, {7'h0, sync_ref_level});
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst         = 1'b1;
    reg_addr    = 16'h0000;
    reg_wr_en   = 1'b0;
    reg_rd_en   = 1'b0;
    reg_wr_data = 8'h00;
    sysref_req  = 1'b0;
    num_errors  = 0;
    num_checks  = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++)
      check_reg(wa[i], 8'h00);
    check_reg(16'h0fb4, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 9; i++)
      reg_write(wa[i], wd[i]);
    reg_write(16'h0fb4, 8'hff);
    for (int i = 0; i < 9; i++)
      check_reg(wa[i], we[i]);
    check_reg(16'h0fb4, 8'h00);
    $display("test register access done");
    check_outs(8'h2f, 8'h5a, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      reg_write(sync_ref_pkg::ADDR_FINE_DELAY, fc[i]);
      check_outs(fe[i], 8'h5a, 1'b1);
    end
    reg_write(sync_ref_pkg::ADDR_DELAY_EN, 8'h02);
    check_outs(8'h00, 8'h5a, 1'b1);
    reg_write(sync_ref_pkg::ADDR_DELAY_EN, 8'h01);
    reg_write(sync_ref_pkg::ADDR_INPUT_MODE, 8'hef);
    check_outs(8'h2f, 8'h00, 1'b0);
    reg_write(sync_ref_pkg::ADDR_DELAY_EN, 8'h00);
    check_outs(8'h00, 8'h00, 1'b0);
    $display("test delay outputs done");
    reg_write(sync_ref_pkg::ADDR_CAPTURE_EN, 8'h00);
    reg_write(sync_ref_pkg::ADDR_EDGE_POLARITY, 8'h00);
    ev_base = ev_count;
    sysref_move(1'b1);
    sysref_move(1'b0);
    check_val("disabled events", 8'h00, 8'(ev_count - ev_base));
    check_val("disabled level", 8'h00, {7'h0, sync_ref_level});
    $display("test capture disabled done");
    reg_write(sync_ref_pkg::ADDR_CAPTURE_EN, 8'h08);
    for (int k = 0; k < 8; k++)
      edge_case(k[2], k[1], k[0]);
    reg_read(sync_ref_pkg::ADDR_SETUP_MARGIN, setup_snap);
    reg_read(sync_ref_pkg::ADDR_HOLD_MARGIN, hold_snap);
    check_val("hold nonzero", 8'h01, {7'h0, hold_snap != 8'h00});
    check_val("setup below hold", 8'h01, {7'h0, setup_snap < hold_snap});
    $display("test capture modes done");
    reg_write(sync_ref_pkg::ADDR_CAPTURE_EN, 8'hf7);
    sysref_move(1'b0);
    sysref_move(1'b1);
    check_reg(sync_ref_pkg::ADDR_SETUP_MARGIN, setup_snap);
    check_reg(sync_ref_pkg::ADDR_HOLD_MARGIN, hold_snap);
    $display("test frozen margins done");
    end_of_test();
  end
endmodule
